// ---- hdl/serial_unit_defines.vh ----
`ifndef SERIAL_UNIT_DEFINES_VH
`define SERIAL_UNIT_DEFINES_VH
// register byte offsets
`define OFS_STATUS 5'h00
`define OFS_DATA 5'h04
`define OFS_CTRL_ONE 5'h08
`define OFS_CTRL_TWO 5'h0C
`define OFS_BAUD 5'h10
`define OFS_TX_FINE 5'h14
`define OFS_RX_FINE 5'h18
// status_reg bit positions
`define ST_TX_EMPTY 7
`define ST_TX_DONE 6
`define ST_RX_FULL 5
`define ST_IDLE 4
`define ST_OVERRUN 3
`define ST_NOISE 2
`define ST_FRAMING 1
`define ST_PARITY 0
// control_reg_one bit positions
`define C1_RX_BIT8 7
`define C1_TX_BIT8 6
`define C1_WORD9 4
`define C1_WAKE 3
`define C1_PAR_EN 2
`define C1_PAR_ODD 1
`define C1_PAR_IRQ 0
// control_reg_two bit positions
`define C2_RX_IRQ 5
`define C2_TX_EN 3
`define C2_RX_EN 2
`define C2_MUTE 1
// baud_rate_reg fields
`define BR_COARSE_HI 7
`define BR_COARSE_LO 6
`define BR_TX_HI 5
`define BR_TX_LO 3
`define BR_RX_HI 2
`define BR_RX_LO 0
// reset values
`define RST_STATUS 8'hC0
`define RST_CTRL 8'h00
`define RST_BAUD 8'h00
`define RST_FINE 8'h00
// oversampling and sample points
`define OVERSAMPLE 16
`define SAMP_3 4'h3
`define SAMP_5 4'h5
`define SAMP_7 4'h7
`define SAMP_8 4'h8
`define SAMP_9 4'h9
`define SAMP_10 4'hA
// idle frame length in sample ticks, 8-bit and 9-bit words
`define IDLE_TICKS_8 8'hA0
`define IDLE_TICKS_9 8'hB0
// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ---- hdl/serial_unit.v ----
// Chosen here: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "serial_unit_defines.vh"
module serial_unit
(
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // axi4-lite write channels
  input wire [4:0] awaddr,
  input wire awvalid,
  output wire awready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output wire wready,
  output reg [1:0] bresp,
  output reg bvalid,
  input wire bready,
  // axi4-lite read channels
  input wire [4:0] araddr,
  input wire arvalid,
  output wire arready,
  output reg [31:0] rdata,
  output reg [1:0] rresp,
  output reg rvalid,
  input wire rready,
  // serial line
  input wire rxd,
  output reg txd,
  // interrupt request level
  output wire irq_request
);

  localparam RX_IDLE = 2'h0;
  localparam RX_START = 2'h1;
  localparam RX_DATA = 2'h2;
  localparam RX_STOP = 2'h3;

  // bus side holding registers
  reg aw_held;
  reg w_held;
  reg [4:0] wr_addr;
  reg [7:0] wr_byte;
  reg wr_lane;
  reg rd_pend;
  reg [4:0] rd_addr;
  // software visible state, plus the status_seen flag that a status read arms
  reg [7:0] status_reg;
  reg [7:0] data_reg;
  reg [7:0] control_reg_one;
  reg [7:0] control_reg_two;
  reg [7:0] baud_rate_reg;
  reg [7:0] tx_fine_prescaler_reg;
  reg [7:0] rx_fine_prescaler_reg;
  reg status_seen;
  // receiver state
  reg rx_meta;
  reg rx_sync;
  reg [1:0] rx_state;
  reg [3:0] rx_scnt;
  reg [3:0] rx_bitn;
  reg [2:0] hist;
  reg s8;
  reg s9;
  reg [8:0] rx_word;
  reg frame_noise;
  reg nf_pend;
  reg idle_armed;
  reg [7:0] idle_cnt;
  // transmitter state
  reg [7:0] tdr;
  reg tdr_bit8;
  reg tdr_full;
  reg tx_busy;
  reg [10:0] tx_frame;
  reg [3:0] tx_bitn;
  reg [3:0] tx_scnt;

  wire wr_fire = aw_held & w_held & ~bvalid;
  wire word9 = control_reg_one[`C1_WORD9];
  wire par_en = control_reg_one[`C1_PAR_EN];
  wire par_odd = control_reg_one[`C1_PAR_ODD];
  wire muted = control_reg_two[`C2_MUTE];
  wire rx_en = control_reg_two[`C2_RX_EN];
  wire tx_en = control_reg_two[`C2_TX_EN];
  wire [3:0] last_bit = word9 ? 4'h8 : 4'h7;
  wire [7:0] frame_ticks = word9 ? `IDLE_TICKS_9 : `IDLE_TICKS_8;
  wire [1:0] tick;
  // majority of samples 8 and 9 with the line at sample 10
  wire maj = (s8 & s9) | (s8 & rx_sync) | (s9 & rx_sync);
  // address mark looks at the top data bit, never at the parity bit
  wire msb = word9 ? (par_en ? rx_word[7] : rx_word[8]) : (par_en ? rx_word[6] : rx_word[7]);
  wire wake = muted & control_reg_one[`C1_WAKE] & msb;
  wire par_bad = par_en & ((word9 ? ^rx_word[8:0] : ^rx_word[7:0]) != par_odd);
  // parity takes the place of the top written data bit
  wire par_tx = (word9 ? ^tdr[7:0] : ^tdr[6:0]) ^ par_odd;
  wire [8:0] tx_word = word9 ? {(par_en ? par_tx : tdr_bit8), tdr}
    : {1'b1, (par_en ? par_tx : tdr[7]), tdr[6:0]};

  // handshake outputs are combinational; one write, one read in flight
  assign awready = ~aw_held & ~bvalid;
  assign wready = ~w_held & ~bvalid;
  assign arready = ~rd_pend & ~rvalid;
  // rx_data_full carries framing and noise; parity has its own enable
  assign irq_request = (status_reg[`ST_RX_FULL] & control_reg_two[`C2_RX_IRQ])
    | (status_reg[`ST_OVERRUN] & control_reg_two[`C2_RX_IRQ])
    | (status_reg[`ST_PARITY] & control_reg_one[`C1_PAR_IRQ]);

  // per-direction baud tick at sixteen times the bit rate; 0 is rx, 1 is tx
  genvar d;
  generate
    for (d = 0; d < 2; d = d + 1)
    begin : g_baud
      reg [18:0] cnt;
      reg [3:0] coarse;
      wire [2:0] sel = (d == 0) ? baud_rate_reg[`BR_RX_HI:`BR_RX_LO]
        : baud_rate_reg[`BR_TX_HI:`BR_TX_LO];
      wire [7:0] fine = (d == 0) ? rx_fine_prescaler_reg : tx_fine_prescaler_reg;
      wire [7:0] fine_eff = (fine == 8'h00) ? 8'h01 : fine;
      wire [18:0] rate = {11'h000, 8'h01 << sel};
      wire [18:0] div = ({15'h0000, coarse} * rate) * {11'h000, fine_eff};
      wire run = (d == 0) ? rx_en : tx_en;
      always @*
      begin
        case (baud_rate_reg[`BR_COARSE_HI:`BR_COARSE_LO])
          2'h0: coarse = 4'h1;
          2'h1: coarse = 4'h3;
          2'h2: coarse = 4'h4;
          default: coarse = 4'hD;
        endcase
      end
      // the divisor is read live, hence software leaves it alone while running
      always @(posedge aclk)
      begin
        if (!aresetn || !run || cnt >= div - 19'h00001)
          cnt <= 19'h00000;
        else
          cnt <= cnt + 19'h00001;
      end
      assign tick[d] = run && (cnt >= div - 19'h00001);
    end
  endgenerate

  // rxd crosses in from the pin through two flops
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
    end
    else
    begin
      rx_meta <= rxd;
      rx_sync <= rx_meta;
    end
  end

  // axi4-lite handshake; write answers the cycle after both halves are held
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      wr_addr <= 5'h00;
      wr_byte <= 8'h00;
      wr_lane <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
      rd_pend <= 1'b0;
      rd_addr <= 5'h00;
    end
    else
    begin
      if (awvalid && awready)
      begin
        aw_held <= 1'b1;
        wr_addr <= awaddr;
      end
      if (wvalid && wready)
      begin
        w_held <= 1'b1;
        wr_byte <= wdata[7:0];
        wr_lane <= wstrb[0];
      end
      if (wr_fire)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        bvalid <= 1'b1;
        bresp <= (wr_addr > `OFS_RX_FINE || wr_addr[1:0] != 2'h0 || wr_addr == `OFS_STATUS)
          ? `RESP_SLVERR : `RESP_OKAY;
      end
      else if (bvalid && bready)
        bvalid <= 1'b0;
      if (arvalid && arready)
      begin
        rd_pend <= 1'b1;
        rd_addr <= araddr;
      end
      else
        rd_pend <= 1'b0;
    end
  end

  // register file, receiver and transmitter share one process so that
  // hardware sets and software clears meet in one place; sets come last
  always @(posedge aclk)
  begin : core
    if (!aresetn)
    begin
      status_reg <= `RST_STATUS;
      data_reg <= 8'h00;
      control_reg_one <= `RST_CTRL;
      control_reg_two <= `RST_CTRL;
      baud_rate_reg <= `RST_BAUD;
      tx_fine_prescaler_reg <= `RST_FINE;
      rx_fine_prescaler_reg <= `RST_FINE;
      status_seen <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= `RESP_OKAY;
      rx_state <= RX_IDLE;
      rx_scnt <= 4'h0;
      rx_bitn <= 4'h0;
      hist <= 3'h7;
      s8 <= 1'b0;
      s9 <= 1'b0;
      rx_word <= 9'h000;
      frame_noise <= 1'b0;
      nf_pend <= 1'b0;
      idle_armed <= 1'b1;
      idle_cnt <= 8'h00;
      tdr <= 8'h00;
      tdr_bit8 <= 1'b0;
      tdr_full <= 1'b0;
      tx_busy <= 1'b0;
      tx_frame <= 11'h7FF;
      tx_bitn <= 4'h0;
      tx_scnt <= 4'h0;
      txd <= 1'b1;
    end
    else
    begin
      // read side: status read arms the clear sequence, data read completes it
      if (rvalid && rready)
        rvalid <= 1'b0;
      if (rd_pend)
      begin
        rvalid <= 1'b1;
        rresp <= `RESP_OKAY;
        rdata <= 32'h00000000;
        case (rd_addr)
          `OFS_STATUS:
          begin
            rdata[7:0] <= status_reg;
            status_seen <= 1'b1;
          end
          `OFS_DATA:
          begin
            rdata[7:0] <= data_reg;
            if (status_seen)
            begin
              status_reg[`ST_RX_FULL] <= 1'b0;
              status_reg[`ST_FRAMING] <= 1'b0;
              status_reg[`ST_NOISE] <= 1'b0;
              status_reg[`ST_OVERRUN] <= 1'b0;
              status_reg[`ST_IDLE] <= 1'b0;
              status_reg[`ST_PARITY] <= 1'b0;
              status_seen <= 1'b0;
            end
          end
          `OFS_CTRL_ONE: rdata[7:0] <= control_reg_one;
          `OFS_CTRL_TWO: rdata[7:0] <= control_reg_two;
          `OFS_BAUD: rdata[7:0] <= baud_rate_reg;
          `OFS_TX_FINE: rdata[7:0] <= tx_fine_prescaler_reg;
          `OFS_RX_FINE: rdata[7:0] <= rx_fine_prescaler_reg;
          default: rresp <= `RESP_SLVERR;
        endcase
      end
      // write side; only byte lane 0 carries register bits
      if (wr_fire && wr_lane)
      begin
        case (wr_addr)
          `OFS_DATA:
          begin
            tdr <= wr_byte;
            tdr_bit8 <= control_reg_one[`C1_TX_BIT8];
            tdr_full <= 1'b1;
            status_reg[`ST_TX_EMPTY] <= 1'b0;
            if (status_seen)
            begin
              status_reg[`ST_TX_DONE] <= 1'b0;
              status_seen <= 1'b0;
            end
          end
          `OFS_CTRL_ONE: control_reg_one[6:0] <= wr_byte[6:0];
          `OFS_CTRL_TWO: control_reg_two <= wr_byte;
          `OFS_BAUD: baud_rate_reg <= wr_byte;
          `OFS_TX_FINE: tx_fine_prescaler_reg <= wr_byte;
          `OFS_RX_FINE: rx_fine_prescaler_reg <= wr_byte;
          default: ;
        endcase
      end
      // receiver, one step per sixteenth of a bit
      if (!rx_en)
      begin
        rx_state <= RX_IDLE;
        hist <= 3'h7;
        idle_cnt <= 8'h00;
      end
      else if (tick[0])
      begin
        rx_scnt <= rx_scnt + 4'h1;
        if (rx_scnt == `SAMP_8)
          s8 <= rx_sync;
        if (rx_scnt == `SAMP_9)
          s9 <= rx_sync;
        case (rx_state)
          RX_IDLE:
          begin
            hist <= {hist[1:0], rx_sync};
            if (!rx_sync)
            begin
              // a line that stays low after a bad stop or a break is no new
              // start; only a high-to-low step opens a frame
              idle_cnt <= 8'h00;
              if (hist[0])
              begin
                // the falling edge restarts the sample phase at sample 1
                rx_state <= RX_START;
                rx_scnt <= 4'h2;
                frame_noise <= (hist != 3'h7);
              end
            end
            else if (idle_cnt < frame_ticks)
            begin
              idle_cnt <= idle_cnt + 8'h01;
              if (idle_cnt == frame_ticks - 8'h01)
              begin
                if (muted && !control_reg_one[`C1_WAKE])
                  control_reg_two[`C2_MUTE] <= 1'b0;
                else if (!muted && idle_armed)
                begin
                  status_reg[`ST_IDLE] <= 1'b1;
                  idle_armed <= 1'b0;
                end
              end
            end
          end
          RX_START:
          begin
            if ((rx_scnt == `SAMP_3 || rx_scnt == `SAMP_5 || rx_scnt == `SAMP_7) && rx_sync)
              frame_noise <= 1'b1;
            if (rx_scnt == `SAMP_10)
            begin
              if (s8 | s9 | rx_sync)
                frame_noise <= 1'b1;
              if (maj)
              begin
                // false start: drop frame, keep noise for the next good one
                nf_pend <= 1'b1;
                rx_state <= RX_IDLE;
                hist <= {3{rx_sync}};
              end
            end
            if (rx_scnt == 4'h0)
            begin
              rx_state <= RX_DATA;
              rx_bitn <= 4'h0;
            end
          end
          RX_DATA:
          begin
            if (rx_scnt == `SAMP_10)
            begin
              rx_word[rx_bitn] <= maj;
              if ((s8 != s9) || (s9 != rx_sync))
                frame_noise <= 1'b1;
            end
            if (rx_scnt == 4'h0)
            begin
              rx_bitn <= rx_bitn + 4'h1;
              if (rx_bitn == last_bit)
                rx_state <= RX_STOP;
            end
          end
          default:
          begin
            // the frame closes at sample 10 of the stop bit so the next
            // start edge is not missed
            if (rx_scnt == `SAMP_10)
            begin
              rx_state <= RX_IDLE;
              hist <= {3{rx_sync}};
              if (!muted || wake)
              begin
                if (wake)
                  control_reg_two[`C2_MUTE] <= 1'b0;
                if (status_reg[`ST_RX_FULL])
                  status_reg[`ST_OVERRUN] <= 1'b1;
                else
                begin
                  data_reg <= rx_word[7:0];
                  control_reg_one[`C1_RX_BIT8] <= rx_word[8];
                  status_reg[`ST_RX_FULL] <= 1'b1;
                  status_reg[`ST_FRAMING] <= ~maj;
                  status_reg[`ST_NOISE] <= frame_noise | nf_pend
                    | (s8 != s9) | (s9 != rx_sync);
                  status_reg[`ST_PARITY] <= par_bad;
                  nf_pend <= 1'b0;
                  idle_armed <= 1'b1;
                end
              end
            end
          end
        endcase
      end
      // transmitter: 11-bit frame vector shifted out lsb first
      if (!tx_en)
      begin
        tx_busy <= 1'b0;
        txd <= 1'b1;
      end
      else if (tick[1])
      begin
        if (!tx_busy)
        begin
          txd <= 1'b1;
          if (tdr_full)
          begin
            tx_frame <= {1'b1, tx_word, 1'b0};
            tdr_full <= 1'b0;
            status_reg[`ST_TX_EMPTY] <= 1'b1;
            tx_busy <= 1'b1;
            tx_bitn <= 4'h0;
            tx_scnt <= 4'h0;
          end
        end
        else
        begin
          txd <= tx_frame[0];
          tx_scnt <= tx_scnt + 4'h1;
          if (tx_scnt == 4'hF)
          begin
            tx_frame <= {1'b1, tx_frame[10:1]};
            tx_bitn <= tx_bitn + 4'h1;
            if (tx_bitn == last_bit + 4'h2)
            begin
              tx_busy <= 1'b0;
              status_reg[`ST_TX_DONE] <= 1'b1;
            end
          end
        end
      end
    end
  end

endmodule // serial_unit
`default_nettype wire

// ---- dv/serial_unit_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module serial_unit_checker (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bus handshakes
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic rvalid,
  input wire logic rready,
  // line and request
  input wire logic txd,
  input wire logic irq_request
);
  // one domain, so clock and reset are given once
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // answers stand unchanged until taken
  a_bresp_holds: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write answer dropped early");
  a_rdata_holds: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read answer dropped early");
  // answers come within a few edges of the take
  a_write_answered: assert property (awvalid && awready && wvalid && wready |-> ##[1:3] bvalid)
    else $error("write not answered");
  a_read_answered: assert property (arvalid && arready |-> ##[1:3] rvalid)
    else $error("read not answered");
  // a pending answer blocks new requests
  a_write_refused: assert property (bvalid |-> !awready && !wready)
    else $error("write taken while answer pending");
  a_read_refused: assert property (rvalid |-> !arready)
    else $error("read taken while answer pending");
  a_rdata_byte: assert property (rvalid |-> rdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  // line idles high and no request right after reset
  a_line_idle: assert property ($rose(aresetn) |-> txd && !irq_request)
    else $error("line or request wrong after reset");
  // a start bit lasts at least eight ticks of one clock
  a_start_long: assert property ($fell(txd) |-> !txd [*8])
    else $error("start bit too short");
endmodule // serial_unit_checker
bind serial_unit serial_unit_checker checker_i (.aclk, .aresetn, .awvalid, .awready, .wvalid, .wready,
  .bresp, .bvalid, .bready, .arvalid, .arready, .rdata, .rvalid, .rready, .txd, .irq_request);
`default_nettype wire

// ---- dv/remote_serial_peer.sv ----
`timescale 1ns/1ps
`default_nettype none
module remote_serial_peer (
  // clock
  input wire logic aclk,
  // serial lines
  output logic line_out,
  input wire logic line_in
);
  // line rests high between frames
  initial line_out = 1'b1;
  // frame bits go out lsb first, each for a whole bit time; bit nz, if any,
  // is inverted for one clock at its ninth sample
  task automatic send(input logic [11:0] fr, input int nb, input int bc, input int nz = -1);
    for (int i = 0; i < nb; i++)
    begin
      line_out <= fr[i];
      if (i == nz)
      begin
        repeat (8) @(posedge aclk);
        line_out <= ~fr[i];
        @(posedge aclk);
        line_out <= fr[i];
        repeat (bc - 9) @(posedge aclk);
      end
      else
        repeat (bc) @(posedge aclk);
    end
    line_out <= 1'b1;
  endtask
  // a low glitch far shorter than a start bit
  task automatic pulse(input int n);
    line_out <= 1'b0;
    repeat (n) @(posedge aclk);
    line_out <= 1'b1;
  endtask
  // sample mid bit so slight skew of the device does not matter
  task automatic catch(input int nb, input int bc, output logic [11:0] fr, output logic ok);
    int n;
    n = 0;
    fr = 12'hFFF;
    while (line_in !== 1'b0 && n < 5000)
    begin
      @(posedge aclk);
      n++;
    end
    ok = n < 5000;
    repeat (bc / 2) @(posedge aclk);
    for (int i = 0; i < nb; i++)
    begin
      fr[i] = line_in;
      repeat (bc) @(posedge aclk);
    end
  endtask
endmodule // remote_serial_peer
`default_nettype wire

// ---- dv/async_serial_rx_baud_mute_parity_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "serial_unit_defines.vh"
module async_serial_rx_baud_mute_parity_tb_top;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [4:0] awaddr, araddr;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  wire awready, wready, bvalid, arready, rvalid, rxd, txd, irq_request;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  int fail_count, checked;
  localparam logic [7:0] rx_mask = 8'h2F;
  logic [7:0] brs [7] = '{8'h00, 8'h49, 8'h92, 8'hC0, 8'h3F, 8'h09, 8'h00};
  logic [7:0] fns [7] = '{8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'h00};
  // design and far end
  serial_unit dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .rxd, .txd, .irq_request);
  remote_serial_peer peer (.aclk, .line_out(rxd), .line_in(txd));
  // 100 ns clock
  initial
  begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  task automatic finish_test;
    $display("mismatches %0d in %0d checks", fail_count, checked);
    if (fail_count == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic hang;
    fail_count++;
    $display("unexpected at %0t: wait ran out", $time);
    finish_test();
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // answers are accepted one edge late so that they must stand
  task automatic axw(input logic [4:0] a, input logic [7:0] d, input logic [1:0] er = `RESP_OKAY);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end
    while (!bvalid && n < 99);
    if (!bvalid)
      hang();
    bready <= 1'b1;
    @(posedge aclk);
    bready <= 1'b0;
    cmp(bresp, er);
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] e, input logic [7:0] m,
                    input logic [1:0] er = `RESP_OKAY);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (arready)
        arvalid <= 1'b0;
    end
    while (!rvalid && n < 99);
    if (!rvalid)
      hang();
    rready <= 1'b1;
    @(posedge aclk);
    rready <= 1'b0;
    cmp(rdata & m, e & m);
    cmp(rresp, er);
  endtask
  function automatic logic [11:0] frame(input logic [8:0] d, input int nd, input logic stop);
    frame = 12'hFFF;
    frame[0] = 1'b0;
    for (int i = 0; i < nd; i++)
      frame[i + 1] = d[i];
    frame[nd + 1] = stop;
  endfunction
  task automatic snd(input logic [8:0] d, input int nd, input logic stop, input int bc);
    peer.send(frame(d, nd, stop), nd + 2, bc);
  endtask
  function automatic int bit_clks(input logic [7:0] br, input logic [7:0] f);
    int c;
    c = br[7:6] == 2'h0 ? 1 : br[7:6] == 2'h1 ? 3 : br[7:6] == 2'h2 ? 4 : 13;
    return 16 * c * (1 << br[2:0]) * (f == 8'h00 ? 1 : int'(f));
  endfunction
  // main sequence
  initial
  begin
    logic [7:0] d;
    logic [8:0] f9;
    logic [11:0] fr;
    logic ok, p;
    int bc;
    {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
    wstrb = 4'h1;
    aresetn = 1'b0;
    fail_count = 0;
    checked = 0;
    void'($urandom(50));
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // reset values, read-only status, unmapped place
    rd(`OFS_STATUS, `RST_STATUS, 8'hFF);
    for (int a = 8; a <= 24; a += 4)
      rd(a[4:0], 8'h00, 8'hFF);
    rd(5'h1C, 8'h00, 8'h00, `RESP_SLVERR);
    axw(`OFS_STATUS, 8'h00, `RESP_SLVERR);
    rd(`OFS_STATUS, `RST_STATUS, 8'hFF);
    // plain words raise full and the request until cleared
    axw(`OFS_CTRL_TWO, 8'h2C);
    repeat (4)
    begin
      d = 8'($urandom);
      snd(d, 8, 1'b1, 16);
      cmp(irq_request, 1'b1);
      rd(`OFS_STATUS, 8'h20, rx_mask);
      rd(`OFS_DATA, d, 8'hFF);
      rd(`OFS_STATUS, 8'h00, rx_mask);
    end
    // missing stop bit and break; a data read alone must not clear
    axw(`OFS_CTRL_TWO, 8'h0C);
    for (int k = 0; k < 2; k++)
    begin
      d = k ? 8'($urandom) : 8'h00;
      rd(`OFS_DATA, 8'h00, 8'h00);
      snd(d, 8, 1'b0, 16);
      cmp(irq_request, 1'b0);
      rd(`OFS_DATA, d, 8'hFF);
      rd(`OFS_STATUS, 8'h22, rx_mask);
      rd(`OFS_DATA, d, 8'hFF);
      rd(`OFS_STATUS, 8'h00, rx_mask);
    end
    // a glitch is no start; its noise shows with the next word
    axw(`OFS_CTRL_TWO, 8'h2C);
    peer.pulse(5);
    repeat (40) @(posedge aclk);
    cmp(irq_request, 1'b0);
    d = 8'($urandom);
    snd(d, 8, 1'b1, 16);
    rd(`OFS_STATUS, 8'h24, rx_mask);
    rd(`OFS_DATA, d, 8'hFF);
    // one disturbed sample in a data bit keeps the bit but flags noise
    d = 8'($urandom);
    peer.send(frame(d, 8, 1'b1), 10, 16, 1 + d[2:0]);
    rd(`OFS_STATUS, 8'h24, rx_mask);
    rd(`OFS_DATA, d, 8'hFF);
    // received parity: both widths, both senses, good and bad
    axw(`OFS_CTRL_TWO, 8'h0C);
    for (int m = 0; m < 8; m++)
    begin
      axw(`OFS_CTRL_ONE, {3'h0, m[2], 2'b01, m[1], 1'b1});
      d = 8'($urandom);
      d[7] = d[7] & m[2];
      p = ^d ^ m[1] ^ m[0];
      f9 = m[2] ? {p, d} : {1'b0, p, d[6:0]};
      snd(f9, m[2] ? 9 : 8, 1'b1, 16);
      cmp(irq_request, m[0]);
      rd(`OFS_STATUS, {7'h10, m[0]}, rx_mask);
      rd(`OFS_DATA, 8'h00, 8'h00);
      rd(`OFS_STATUS, 8'h00, rx_mask);
    end
    // sent parity takes the place of the top data bit
    for (int m = 0; m < 2; m++)
    begin
      d = 8'($urandom);
      axw(`OFS_CTRL_ONE, {6'h01, m[0], 1'b0});
      axw(`OFS_DATA, d);
      peer.catch(10, 16, fr, ok);
      if (!ok)
        hang();
      cmp(fr[9:0], {1'b1, ^d[6:0] ^ m[0], d[6:0], 1'b0});
    end
    axw(`OFS_CTRL_ONE, 8'h00);
    // seven rate settings covering every coarse step, both directions, changed only while disabled
    for (int i = 0; i < 7; i++)
    begin
      bc = bit_clks(brs[i], fns[i]);
      axw(`OFS_CTRL_TWO, 8'h00);
      axw(`OFS_BAUD, brs[i]);
      axw(`OFS_TX_FINE, fns[i]);
      axw(`OFS_RX_FINE, fns[i]);
      axw(`OFS_CTRL_TWO, 8'h0C);
      d = 8'($urandom);
      snd(d, 8, 1'b1, bc);
      rd(`OFS_STATUS, 8'h20, rx_mask);
      rd(`OFS_DATA, d, 8'hFF);
      d = 8'($urandom);
      axw(`OFS_DATA, d);
      peer.catch(10, bc, fr, ok);
      if (!ok)
        hang();
      cmp(fr[9:0], {1'b1, d, 1'b0});
    end
    // muted word is ignored, then an idle frame wakes quietly
    repeat (200) @(posedge aclk);
    rd(`OFS_STATUS, 8'h00, 8'h00);
    rd(`OFS_DATA, 8'h00, 8'h00);
    axw(`OFS_CTRL_TWO, 8'h2E);
    snd(8'($urandom), 8, 1'b1, 16);
    cmp(irq_request, 1'b0);
    rd(`OFS_STATUS, 8'h00, 8'h3F);
    repeat (200) @(posedge aclk);
    rd(`OFS_CTRL_TWO, 8'h2C, 8'hFF);
    rd(`OFS_STATUS, 8'h00, 8'h3F);
    // address mark: top data bit wakes, parity bit does not
    axw(`OFS_CTRL_ONE, 8'h0C);
    axw(`OFS_CTRL_TWO, 8'h2E);
    snd(9'h081, 8, 1'b1, 16);
    cmp(irq_request, 1'b0);
    snd(9'h041, 8, 1'b1, 16);
    cmp(irq_request, 1'b1);
    rd(`OFS_CTRL_TWO, 8'h2C, 8'hFF);
    rd(`OFS_STATUS, 8'h20, rx_mask);
    rd(`OFS_DATA, 8'h41, 8'h7F);
    finish_test();
  end
endmodule // async_serial_rx_baud_mute_parity_tb_top
`default_nettype wire
